//--- verilog/plr_pkg.sv
/*
 * Constants, types and register map of the packet length and register
 * patch loader. Assumes nothing of its surroundings.
 */
`default_nettype none
package plr_pkg;
	// ************************************************************
	// Register map (word indices; byte address is four times these)
	// ************************************************************
	localparam logic [8:0] CFG_BASE_IDX     = 9'h100;
	localparam logic [8:0] CFG_LAST_IDX     = 9'h13f;
	localparam logic [8:0] MAX_PKT_IDX      = 9'h127;
	localparam logic [8:0] PATCH_PTR_IDX    = 9'h128;
	localparam logic [8:0] CTRL_IDX         = 9'h140;
	localparam logic [8:0] STATUS_IDX       = 9'h141;
	localparam int         CFG_DEPTH        = 64;
	localparam int         CFG_AW           = 6;
	// ************************************************************
	// Control and status fields
	// ************************************************************
	localparam int         CTRL_FIXED_BIT   = 0;
	localparam int         CTRL_OFS_LSB     = 1;
	localparam int         CTRL_START_BIT   = 7;
	localparam int         STAT_BUSY_BIT    = 0;
	localparam int         STAT_ERR_BIT     = 1;
	localparam int         STAT_CNT_LSB     = 4;
	// ************************************************************
	// Patch table constants
	// ************************************************************
	localparam logic [7:0] PTR_OFF          = 8'h00;
	localparam logic [7:0] PTR_MIN          = 8'h2a;
	localparam logic [7:0] PTR_MAX          = 8'h3d;
	localparam logic [7:0] TABLE_END        = 8'h00;
	localparam logic [1:0] MODEM_PAGE       = 2'h3;
	localparam int         MAX_PATCHES      = 9;
	localparam logic [7:0] BYTE_RST         = 8'h00;

	typedef enum logic [1:0] {
		PLR_IDLE = 2'b00,
		PLR_ADDR = 2'b01,
		PLR_DATA = 2'b10
	} plr_state_t;

	typedef struct packed {
		logic       valid;
		logic [9:0] addr;
		logic [7:0] data;
	} plr_modem_wr_t;

	typedef struct packed {
		logic       fixed;
		logic [7:0] length;
		logic [2:0] offset;
	} plr_len_cfg_t;
endpackage
`default_nettype wire

//--- verilog/plr_loader.sv
/*
 * Packet length limit and static register patch loader with its slice of
 * the battery-backed configuration memory, reached over Avalon-MM.
 * Assumes an Avalon master on i_clk using word addresses, and packet
 * logic on the same clock that reports each received payload length.
 */
// How it works
// - Length-control zero: length register is the largest receive length accepted.
// - Length-control one: length register is the exact transmit and receive length.
// - Length counts bytes from sync word end to CRC start, offset excluded.
// - Patch pointer may select any location 0x12A through 0x13D.
// - Pointer holds only the low byte; 0x2B means location 0x12B.
// - Pointer zero: no patching is done at all.
// - Nonzero pointer 0x2A to 0x3D: read address byte then data byte starting there; other values set the error bit.
// - At most nine modem registers are written per run.
// - Table is address and data pairs; address byte zero ends it.
// - Length-control bit one selects fixed length, zero selects variable.
`timescale 1ns/1ns
`default_nettype none
module plr_loader #(
	parameter int MAX_PATCHES = plr_pkg::MAX_PATCHES
) (
	input  wire logic               i_clk,
	input  wire logic               i_arst_n,
	input  wire logic [8:0]         i_avs_address,
	input  wire logic               i_avs_read,
	input  wire logic               i_avs_write,
	input  wire logic [31:0]        i_avs_writedata,
	input  wire logic [3:0]         i_avs_byteenable,
	output logic [31:0]             o_avs_readdata,
	output logic                    o_avs_waitrequest,
	input  wire logic               i_rx_len_valid,
	input  wire logic [7:0]         i_rx_len,
	output logic                    o_rx_len_err,
	output plr_pkg::plr_len_cfg_t   o_len_cfg,
	output plr_pkg::plr_modem_wr_t  o_modem_wr,
	output logic                    o_patch_busy
);
	// ************************************************************
	// Elaboration checks
	// ************************************************************
	generate
		if (MAX_PATCHES < 1 || MAX_PATCHES > 15) begin : g_bad
			$error("MAX_PATCHES must lie in 1 to 15.");
		end
	endgenerate

	// ************************************************************
	// Bus slave
	// ************************************************************
	logic [7:0]  cfg_q [plr_pkg::CFG_DEPTH];
	logic        wait_q, wait_d;
	logic [31:0] rdata_q, rdata_d;
	logic        fixed_q, fixed_d;
	logic [2:0]  ofs_q, ofs_d;
	logic        start_q, start_d;
	logic        err_q, err_d;
	logic [3:0]  cnt_q, cnt_d;
	logic        req, take, wr_cfg;
	logic [7:0]  wbyte;

	assign req    = i_avs_read | i_avs_write;
	assign take   = req & ~wait_q;
	assign wbyte  = i_avs_writedata[7:0];
	assign wr_cfg = take & i_avs_write & i_avs_byteenable[0]
		& (i_avs_address >= plr_pkg::CFG_BASE_IDX) & (i_avs_address <= plr_pkg::CFG_LAST_IDX);

	always_comb begin
		wait_d  = ~(req & wait_q);
		rdata_d = rdata_q;
		fixed_d = fixed_q;
		ofs_d   = ofs_q;
		start_d = 1'b0;
		if (req & wait_q) begin
			rdata_d = 32'h0000_0000;
			if (i_avs_address >= plr_pkg::CFG_BASE_IDX && i_avs_address <= plr_pkg::CFG_LAST_IDX) begin
				rdata_d[7:0] = cfg_q[i_avs_address[plr_pkg::CFG_AW-1:0]];
			end else if (i_avs_address == plr_pkg::CTRL_IDX) begin
				rdata_d[plr_pkg::CTRL_FIXED_BIT] = fixed_q;
				rdata_d[plr_pkg::CTRL_OFS_LSB +: 3] = ofs_q;
			end else if (i_avs_address == plr_pkg::STATUS_IDX) begin
				rdata_d[plr_pkg::STAT_BUSY_BIT] = o_patch_busy;
				rdata_d[plr_pkg::STAT_ERR_BIT]  = err_q;
				rdata_d[plr_pkg::STAT_CNT_LSB +: 4] = cnt_q;
			end
		end
		if (take & i_avs_write & i_avs_byteenable[0] & (i_avs_address == plr_pkg::CTRL_IDX)) begin
			fixed_d = wbyte[plr_pkg::CTRL_FIXED_BIT];
			ofs_d   = wbyte[plr_pkg::CTRL_OFS_LSB +: 3];
			start_d = wbyte[plr_pkg::CTRL_START_BIT];
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wait_q  <= 1'b1;
			rdata_q <= 32'h0000_0000;
			fixed_q <= 1'b0;
			ofs_q   <= 3'h0;
			start_q <= 1'b0;
		end else begin
			wait_q  <= wait_d;
			rdata_q <= rdata_d;
			fixed_q <= fixed_d;
			ofs_q   <= ofs_d;
			start_q <= start_d;
		end
	end

	// Configuration memory; software writes land in the same edge that acknowledges them.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			for (int i = 0; i < plr_pkg::CFG_DEPTH; i++) begin
				cfg_q[i] <= plr_pkg::BYTE_RST;
			end
		end else if (wr_cfg) begin
			cfg_q[i_avs_address[plr_pkg::CFG_AW-1:0]] <= wbyte;
		end
	end

	assign o_avs_waitrequest = wait_q;
	assign o_avs_readdata    = rdata_q;

	// ************************************************************
	// Packet length check
	// ************************************************************
	logic         len_err_q, len_err_d;
	plr_pkg::plr_len_cfg_t len_cfg_q, len_cfg_d;
	logic [7:0]   max_len;

	assign max_len = cfg_q[plr_pkg::MAX_PKT_IDX[plr_pkg::CFG_AW-1:0]];

	// The reported length is the payload between sync word and CRC, with no offset added,
	// so it compares straight against the register.
	always_comb begin
		len_cfg_d.fixed  = fixed_q;
		len_cfg_d.length = max_len;
		len_cfg_d.offset = ofs_q;
		len_err_d = 1'b0;
		if (i_rx_len_valid) begin
			if (fixed_q) begin
				len_err_d = (i_rx_len != max_len);
			end else begin
				len_err_d = (i_rx_len > max_len);
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			len_err_q <= 1'b0;
			len_cfg_q <= '0;
		end else begin
			len_err_q <= len_err_d;
			len_cfg_q <= len_cfg_d;
		end
	end

	assign o_rx_len_err = len_err_q;
	assign o_len_cfg    = len_cfg_q;

	// ************************************************************
	// Static register patch engine
	// ************************************************************
	plr_pkg::plr_state_t  st_q, st_d;
	logic [7:0]           cur_q, cur_d;
	logic [7:0]           adr_q, adr_d;
	plr_pkg::plr_modem_wr_t mdm_q, mdm_d;
	logic [7:0]           ptr, rd_byte;
	logic                 cur_in;
	logic                 busy_q, busy_d;

	assign ptr     = cfg_q[plr_pkg::PATCH_PTR_IDX[plr_pkg::CFG_AW-1:0]];
	assign cur_in  = (cur_q[7:plr_pkg::CFG_AW] == 2'h0);
	assign rd_byte = cfg_q[cur_q[plr_pkg::CFG_AW-1:0]];

	always_comb begin
		st_d  = st_q;
		cur_d = cur_q;
		adr_d = adr_q;
		cnt_d = cnt_q;
		err_d = err_q;
		mdm_d = '0;
		unique case (st_q)
			plr_pkg::PLR_IDLE: begin
				if (start_q) begin
					cnt_d = 4'h0;
					err_d = 1'b0;
					cur_d = ptr;
					if (ptr == plr_pkg::PTR_OFF) begin
						st_d = plr_pkg::PLR_IDLE;
					end else if (ptr < plr_pkg::PTR_MIN || ptr > plr_pkg::PTR_MAX) begin
						err_d = 1'b1;
					end else begin
						st_d = plr_pkg::PLR_ADDR;
					end
				end
			end
			plr_pkg::PLR_ADDR: begin
				if (!cur_in || rd_byte == plr_pkg::TABLE_END) begin
					st_d = plr_pkg::PLR_IDLE;
				end else begin
					adr_d = rd_byte;
					cur_d = cur_q + 8'h01;
					st_d  = plr_pkg::PLR_DATA;
				end
			end
			plr_pkg::PLR_DATA: begin
				if (!cur_in) begin
					st_d = plr_pkg::PLR_IDLE;
				end else begin
					mdm_d.valid = 1'b1;
					mdm_d.addr  = {plr_pkg::MODEM_PAGE, adr_q};
					mdm_d.data  = rd_byte;
					cnt_d = cnt_q + 4'h1;
					cur_d = cur_q + 8'h01;
					if (cnt_q + 4'h1 >= 4'(MAX_PATCHES)) begin
						st_d = plr_pkg::PLR_IDLE;
					end else begin
						st_d = plr_pkg::PLR_ADDR;
					end
				end
			end
			default: st_d = plr_pkg::PLR_IDLE;
		endcase
		busy_d = (st_d != plr_pkg::PLR_IDLE);
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_q  <= plr_pkg::PLR_IDLE;
			cur_q <= 8'h00;
			adr_q <= 8'h00;
			cnt_q <= 4'h0;
			err_q <= 1'b0;
			mdm_q <= '0;
			busy_q <= 1'b0;
		end else begin
			st_q  <= st_d;
			cur_q <= cur_d;
			adr_q <= adr_d;
			cnt_q <= cnt_d;
			err_q <= err_d;
			mdm_q <= mdm_d;
			busy_q <= busy_d;
		end
	end

	// Busy has its own flip-flop so that the output carries no decode glitches.
	assign o_patch_busy = busy_q;
	assign o_modem_wr   = mdm_q;
endmodule
`default_nettype wire

//--- verification/plr_loader_sva.sv
/* Checker for plr_loader. Sees only its ports; bound below. */
`timescale 1ns/1ns
`default_nettype none
module plr_loader_sva #(parameter int MAX_PATCHES = 9) (
	input wire logic                  i_clk, i_arst_n, i_avs_read, i_avs_write, o_avs_waitrequest,
	input wire logic                  i_rx_len_valid, o_rx_len_err, o_patch_busy,
	input wire logic [7:0]            i_rx_len,
	input wire plr_pkg::plr_len_cfg_t o_len_cfg,
	input wire plr_pkg::plr_modem_wr_t o_modem_wr
);
	logic [3:0] n_q;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	// Counts writes of the current run, so the cap holds across one run.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) n_q <= 4'h0;
		else if ($rose(o_patch_busy)) n_q <= 4'h0;
		else if (o_modem_wr.valid) n_q <= n_q + 4'h1;
	end
	property p_ack; (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest; endproperty
	a_ack: assert property (p_ack) else $error("bus answer late");
	property p_one; !o_avs_waitrequest |=> o_avs_waitrequest; endproperty
	a_one: assert property (p_one) else $error("wait low too long");
	property p_var; i_rx_len_valid && !o_len_cfg.fixed |=> o_rx_len_err == ($past(i_rx_len) > $past(o_len_cfg.length)); endproperty
	a_var: assert property (p_var) else $error("variable length check wrong");
	property p_fix; i_rx_len_valid && o_len_cfg.fixed |=> o_rx_len_err == ($past(i_rx_len) != $past(o_len_cfg.length)); endproperty
	a_fix: assert property (p_fix) else $error("fixed length check wrong");
	property p_src; o_rx_len_err |-> $past(i_rx_len_valid); endproperty
	a_src: assert property (p_src) else $error("length error without length");
	property p_page; o_modem_wr.valid |-> o_modem_wr.addr[9:8] == 2'h3 && o_modem_wr.addr[7:0] != 8'h00; endproperty
	a_page: assert property (p_page) else $error("bad modem address");
	property p_gap; o_modem_wr.valid |=> !o_modem_wr.valid; endproperty
	a_gap: assert property (p_gap) else $error("writes too close");
	property p_cap; o_modem_wr.valid |-> n_q < MAX_PATCHES; endproperty
	a_cap: assert property (p_cap) else $error("too many writes");
	property p_run; o_modem_wr.valid |-> $past(o_patch_busy); endproperty
	a_run: assert property (p_run) else $error("write outside a run");
endmodule
bind plr_loader plr_loader_sva #(.MAX_PATCHES(MAX_PATCHES)) plr_loader_sva_inst (.*);
`default_nettype wire

//--- verification/tb_top.sv
/* Self-checking bench for plr_loader. Assumes the checker is compiled with it. */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	typedef struct {string n; logic [31:0] v;} plr_exp_t;
	logic                  i_clk = 1'b0, i_arst_n = 1'b0, rd = 1'b0, wr = 1'b0, lv = 1'b0, seen = 1'b0;
	logic [8:0]            adr = 9'h000;
	logic [31:0]           wd = 32'h0, rdata;
	logic [7:0]            len = 8'h00, mx, rv;
	logic                  wt, err, busy;
	plr_pkg::plr_len_cfg_t cfg;
	plr_pkg::plr_modem_wr_t mw;
	plr_exp_t              q[$];
	int                    err_count = 0, n_checks = 0, cyc = 0, seed = 59;
	always #5 i_clk = ~i_clk;
	plr_loader plr_loader_inst (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_avs_address(adr), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'h1), .o_avs_readdata(rdata),
		.o_avs_waitrequest(wt), .i_rx_len_valid(lv), .i_rx_len(len), .o_rx_len_err(err), .o_len_cfg(cfg),
		.o_modem_wr(mw), .o_patch_busy(busy));
	task automatic report_and_stop();
		$display("Checks %0d, mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic chk(string n, logic [31:0] v);
		plr_exp_t e;
		n_checks++;
		if (q.size() == 0) e = '{"none", 32'hffff_ffff};
		else e = q.pop_front();
		if (e.v !== v || e.n != n) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e.v, v);
		end
	endtask
	// Settled values are taken at the falling edge, clear of the launch edge.
	always @(negedge i_clk) if (i_arst_n) begin
		if (rd && !wt) chk("readdata", rdata);
		if (mw.valid) chk("modem_write", {14'h0, mw.addr, mw.data});
		if (seen) chk("len_err", {31'h0, err});
		seen = lv;
	end
	always @(posedge i_clk) begin
		cyc++;
		if (cyc > 20000) begin
			err_count++;
			report_and_stop();
		end
	end
	task automatic bus(logic w, logic [8:0] a, logic [7:0] d);
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= {24'h0, d};
		do @(posedge i_clk); while (wt !== 1'b0);
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic rdchk(logic [8:0] a, logic [7:0] v);
		q.push_back('{"readdata", {24'h0, v}});
		bus(1'b0, a, 8'h00);
	endtask
	task automatic lenchk(logic f, logic [7:0] l);
		q.push_back('{"len_err", {31'h0, f ? l != mx : l > mx}});
		lv <= 1'b1;
		len <= l;
		@(posedge i_clk);
		lv <= 1'b0;
		len <= ~l;
		@(posedge i_clk);
	endtask
	// A table of n random pairs at pointer p, then start and read back status.
	task automatic patch(logic [7:0] p, int n);
		int k;
		int c;
		logic ok;
		logic [7:0] dv;
		ok = p >= plr_pkg::PTR_MIN && p <= plr_pkg::PTR_MAX;
		c = ok ? ((n < plr_pkg::MAX_PATCHES) ? n : plr_pkg::MAX_PATCHES) : 0;
		bus(1'b1, 9'h128, p);
		for (k = 0; ok && k <= n; k++) begin
			rv = (k == n) ? 8'h00 : 8'($random(seed)) | 8'h01;
			bus(1'b1, {1'b1, p} + 9'(2 * k), rv);
			if (k < n) begin
				dv = 8'($random(seed));
				bus(1'b1, {1'b1, p} + 9'(2 * k + 1), dv);
				if (k < c) q.push_back('{"modem_write", {14'h0, 2'h3, rv, dv}});
			end
		end
		bus(1'b1, 9'h140, 8'h80);
		repeat (3) @(posedge i_clk);
		for (k = 0; k < 40 && busy !== 1'b0; k++) @(posedge i_clk);
		rdchk(9'h141, {4'(c), 2'h0, !ok && p != 8'h00, 1'b0});
		$display("Test patch pointer %h done", p);
	endtask
	initial begin
		repeat (5) @(posedge i_clk);
		i_arst_n <= 1'b1;
		@(posedge i_clk);
		rdchk(9'h127, 8'h00);
		rdchk(9'h128, 8'h00);
		bus(1'b1, 9'h1ff, 8'h5a);
		rdchk(9'h1ff, 8'h00);
		$display("Test registers done");
		for (int f = 0; f < 2; f++) begin
			mx = 8'($random(seed));
			bus(1'b1, 9'h127, mx);
			bus(1'b1, 9'h140, {7'h0, 1'(f)});
			rdchk(9'h127, mx);
			for (int k = 0; k < 4; k++) lenchk(1'(f), k == 3 ? 8'($random(seed)) : mx + 8'(k) - 8'h01);
			$display("Test length mode %0d done", f);
		end
		patch(8'h2b, 2);
		patch(8'h2a, 10);
		patch(8'h3d, 1);
		patch(8'h00, 0);
		patch(8'h3e, 0);
		report_and_stop();
	end
endmodule
`default_nettype wire
